// file: hw/rph_packet_handler.sv
// Receive packet handler: config registers, bit decoder, packet engine, FIFO, auto modes
//
// Functional notes
// - Format bit: 0 fixed length, 1 variable length; resets to 0.
// - Decoding field: 00 none, 01 Manchester, 10 de-whitening, 11 reserved.
// - Checksum checked on payloads only while enable bit is 1; resets to 1.
// - Checksum fail with keep bit 0: flush FIFO, restart, no body-complete flag.
// - Checksum fail with keep bit 1: keep FIFO bytes, still raise body-complete.
// - Filter field: 00 off, 01 own node, 10 own node or broadcast.
// - Length register: exact length fixed, maximum length variable; resets to 0x40.
// - Own-node and broadcast id registers reset to 0x00, feed the filter.
// - Entry trigger 000 off, 001-101 rising flag edges, 111 FIFO empty.
// - Leave trigger: 001 FIFO empty, 010-101 flag edge or timeout, 111 timeout.
// - Temporary state select: 00 sleep, 01 standby, 10 receive.
// - Seven-bit FIFO threshold resets to fifteen; bit 7 unused, resets to 1.
// - Above-limit flag high only while FIFO count strictly exceeds threshold.
// - Frame-match flag set after sync and address, or at sync with filter off; clears leaving receive or FIFO empty.
// - Body-complete set after last byte with checksum off, else after the checksum bytes unless a failed check flushes; clears on FIFO empty.
`timescale 1ns/1ps
module rph_packet_handler #(
  parameter int FIFO_DEPTH = 66
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic rx_chip_in,
  input wire logic rx_chip_valid_in,
  input wire logic sync_found_in,
  input wire logic timeout_in,
  output logic [1:0] mode_out,
  output logic irq_out
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? rph_pkg::CRC_POLY : 16'h0000);
  endfunction

  function automatic logic fld_hit(input logic [11:0] a, input logic [7:0] idx);
    fld_hit = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
  endfunction

  // Registers
  logic [7:0] packet_format_config, payload_length, own_node_address;
  logic [7:0] broadcast_node_address, auto_mode_sequencer, fifo_level_threshold;
  logic [5:0] irq_status, irq_mask;
  logic [1:0] op_mode;
  logic [7:0] next_packet_format_config, next_payload_length, next_own_node_address;
  logic [7:0] next_broadcast_node_address, next_auto_mode_sequencer;
  logic [7:0] next_fifo_level_threshold;
  logic [5:0] next_irq_status, next_irq_mask;
  logic [1:0] next_op_mode;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;
  // Core state
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [CW-1:0] fifo_wr, fifo_rd, fifo_cnt, next_fifo_wr, next_fifo_rd, next_fifo_cnt;
  rph_pkg::rph_pkt_e pkt_state, next_pkt_state;
  logic [7:0] shift, next_shift, byte_left, next_byte_left;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic half, next_half, first_chip, next_first_chip;
  logic [8:0] lfsr, next_lfsr;
  logic [15:0] crc, next_crc;
  logic [7:0] crc_hi, next_crc_hi;
  logic addr_pending, next_addr_pending;
  logic frame_match, body_complete, checksum_good, temp_active;
  logic next_frame_match, next_body_complete, next_checksum_good, next_temp_active;
  logic [3:0] prev_flags;
  logic [1:0] mode_q, next_mode;

  // Decoded fields
  logic length_format_select, checksum_enable, checksum_fail_keep;
  logic [1:0] line_decoding_select, addr_filter_select, temp_state_select;
  logic [2:0] auto_entry_trigger, auto_leave_trigger;
  logic [6:0] queue_level_limit;
  assign length_format_select = packet_format_config[rph_pkg::POS_LENGTH_FORMAT];
  assign line_decoding_select = packet_format_config[rph_pkg::POS_DECODING_LO +: 2];
  assign checksum_enable = packet_format_config[rph_pkg::POS_CHECKSUM_ENABLE];
  assign checksum_fail_keep = packet_format_config[rph_pkg::POS_CHECKSUM_FAIL_KEEP];
  assign addr_filter_select = packet_format_config[rph_pkg::POS_ADDR_FILTER_LO +: 2];
  assign auto_entry_trigger = auto_mode_sequencer[rph_pkg::POS_ENTRY_LO +: 3];
  assign auto_leave_trigger = auto_mode_sequencer[rph_pkg::POS_LEAVE_LO +: 3];
  assign temp_state_select = auto_mode_sequencer[rph_pkg::POS_TEMP_LO +: 2];
  assign queue_level_limit = fifo_level_threshold[6:0];

  logic queue_has_data_flag, queue_above_limit_flag, queue_full;
  assign queue_has_data_flag = (fifo_cnt != '0);
  assign queue_above_limit_flag = (fifo_cnt > CW'(queue_level_limit));
  assign queue_full = (fifo_cnt == CW'(FIFO_DEPTH));

  // APB access qualifiers; the slave inserts one wait state before completing
  logic acc_done, wr_done, rd_done;
  assign acc_done = psel_in && penable_in && pready_out;
  assign wr_done = acc_done && pwrite_in;
  assign rd_done = acc_done && !pwrite_in;
  logic pop;
  assign pop = rd_done && fld_hit(paddr_in, rph_pkg::IDX_FIFO_DATA) && queue_has_data_flag;

  logic [6:0] flag_status;
  assign flag_status = {queue_full, temp_active, queue_has_data_flag, queue_above_limit_flag,
                        checksum_good, body_complete, frame_match};

  // Receive decoding and packet engine
  logic rx_active, bit_ok, dec_bit, byte_done, push, restart, flush;
  logic [7:0] dec_byte;
  logic [3:0] rise;
  logic [5:0] irq_set;
  logic leave_rx, fifo_empty_evt, crc_fail_evt;
  logic [15:0] crc_rx;
  always_comb
  begin
    next_pkt_state = pkt_state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_half = half;
    next_first_chip = first_chip;
    next_lfsr = lfsr;
    next_crc = crc;
    next_crc_hi = crc_hi;
    next_byte_left = byte_left;
    next_addr_pending = addr_pending;
    next_frame_match = frame_match;
    next_body_complete = body_complete;
    next_checksum_good = checksum_good;
    bit_ok = 1'b0;
    dec_bit = rx_chip_in;
    byte_done = 1'b0;
    dec_byte = {shift[6:0], dec_bit};
    push = 1'b0;
    restart = 1'b0;
    flush = 1'b0;
    crc_fail_evt = 1'b0;
    crc_rx = {crc_hi, dec_byte};
    rx_active = (mode_q == rph_pkg::MODE_RECEIVE);
    leave_rx = rx_active && (next_mode != rph_pkg::MODE_RECEIVE);
    if (rx_active && rx_chip_valid_in && pkt_state != rph_pkg::PS_HUNT
        && pkt_state != rph_pkg::PS_HOLD)
    begin
      case (line_decoding_select)
        rph_pkg::DEC_MANCHESTER:
        begin
          // A high-then-low chip pair carries a one; the second chip is not checked
          next_half = !half;
          next_first_chip = rx_chip_in;
          bit_ok = half;
          dec_bit = first_chip;
        end
        rph_pkg::DEC_WHITEN:
        begin
          bit_ok = 1'b1;
          dec_bit = rx_chip_in ^ lfsr[0];
          next_lfsr = {lfsr[0] ^ lfsr[5], lfsr[8:1]};
        end
        default:
        begin
          bit_ok = 1'b1;
          dec_bit = rx_chip_in;
        end
      endcase
    end
    dec_byte = {shift[6:0], dec_bit};
    crc_rx = {crc_hi, dec_byte};
    if (bit_ok)
    begin
      next_shift = dec_byte;
      next_bit_cnt = bit_cnt + 3'd1;
      byte_done = (bit_cnt == 3'd7);
    end
    if (bit_ok && (pkt_state == rph_pkg::PS_LEN || pkt_state == rph_pkg::PS_BODY))
      next_crc = crc_bit(crc, dec_bit);
    case (pkt_state)
      rph_pkg::PS_HUNT:
        if (rx_active && sync_found_in)
        begin
          next_bit_cnt = 3'd0;
          next_half = 1'b0;
          next_lfsr = rph_pkg::WHITEN_SEED;
          next_crc = rph_pkg::CRC_SEED;
          next_byte_left = payload_length;
          next_addr_pending = (addr_filter_select != rph_pkg::FILT_OFF);
          next_frame_match = (addr_filter_select == rph_pkg::FILT_OFF);
          next_pkt_state = length_format_select ? rph_pkg::PS_LEN : rph_pkg::PS_BODY;
        end
      rph_pkg::PS_LEN:
        if (byte_done)
        begin
          // Length counts the address byte and the payload
          if (dec_byte == 8'h00 || dec_byte > payload_length)
            restart = 1'b1;
          else
          begin
            push = 1'b1;
            next_byte_left = dec_byte;
            next_pkt_state = rph_pkg::PS_BODY;
          end
        end
      rph_pkg::PS_BODY:
        if (byte_done)
        begin
          if (addr_pending && !(dec_byte == own_node_address
              || (addr_filter_select == rph_pkg::FILT_NODE_BCAST
              && dec_byte == broadcast_node_address)))
            restart = 1'b1;
          else
          begin
            push = 1'b1;
            next_addr_pending = 1'b0;
            if (addr_pending)
              next_frame_match = 1'b1;
            next_byte_left = byte_left - 8'd1;
            if (byte_left == 8'd1)
            begin
              if (checksum_enable)
                next_pkt_state = rph_pkg::PS_CRC_HI;
              else
              begin
                next_body_complete = 1'b1;
                next_pkt_state = rph_pkg::PS_HOLD;
              end
            end
          end
        end
      rph_pkg::PS_CRC_HI:
        if (byte_done)
        begin
          next_crc_hi = dec_byte;
          next_pkt_state = rph_pkg::PS_CRC_LO;
        end
      rph_pkg::PS_CRC_LO:
        if (byte_done)
        begin
          if (crc_rx == crc)
          begin
            next_checksum_good = 1'b1;
            next_body_complete = 1'b1;
            next_pkt_state = rph_pkg::PS_HOLD;
          end
          else
          begin
            crc_fail_evt = 1'b1;
            if (checksum_fail_keep)
            begin
              next_body_complete = 1'b1;
              next_pkt_state = rph_pkg::PS_HOLD;
            end
            else
            begin
              flush = 1'b1;
              restart = 1'b1;
            end
          end
        end
      rph_pkg::PS_HOLD:
        // Next packet waits until software has drained the FIFO
        if (!queue_has_data_flag)
          next_pkt_state = rph_pkg::PS_HUNT;
      default:
        next_pkt_state = rph_pkg::PS_HUNT;
    endcase
    if (restart)
    begin
      next_pkt_state = rph_pkg::PS_HUNT;
      next_frame_match = 1'b0;
    end
    if (restart && !length_format_select && !flush && pkt_state == rph_pkg::PS_BODY)
      flush = 1'b1;
    if (restart && pkt_state != rph_pkg::PS_LEN)
      flush = 1'b1;
    if (leave_rx)
    begin
      next_pkt_state = rph_pkg::PS_HUNT;
      next_frame_match = 1'b0;
    end
    // FIFO bookkeeping; a flush drops any byte of the current frame
    next_fifo_wr = fifo_wr;
    next_fifo_rd = fifo_rd;
    next_fifo_cnt = fifo_cnt;
    if (flush)
    begin
      next_fifo_wr = '0;
      next_fifo_rd = '0;
      next_fifo_cnt = '0;
    end
    else
    begin
      if (push && !queue_full)
        next_fifo_wr = (fifo_wr == CW'(FIFO_DEPTH - 1)) ? '0 : fifo_wr + CW'(1);
      if (pop)
        next_fifo_rd = (fifo_rd == CW'(FIFO_DEPTH - 1)) ? '0 : fifo_rd + CW'(1);
      next_fifo_cnt = fifo_cnt + CW'(push && !queue_full) - CW'(pop);
    end
    fifo_empty_evt = queue_has_data_flag && (next_fifo_cnt == '0);
    if (next_fifo_cnt == '0)
    begin
      next_body_complete = 1'b0;
      next_checksum_good = 1'b0;
      if (queue_has_data_flag)
        next_frame_match = 1'b0;
    end
  end

  // Auto-mode sequencer; edges are seen on the registered flags
  logic entry_evt, leave_evt;
  always_comb
  begin
    rise = {queue_above_limit_flag, checksum_good, body_complete, frame_match}
           & ~prev_flags;
    case (auto_entry_trigger)
      // Only the empty-to-filled step counts, not a FIFO that sits at one byte
      3'b001: entry_evt = !queue_has_data_flag && (next_fifo_cnt != '0);
      3'b010: entry_evt = rise[3];
      3'b011: entry_evt = rise[2];
      3'b100: entry_evt = rise[1];
      3'b101: entry_evt = rise[0];
      3'b111: entry_evt = fifo_empty_evt;
      default: entry_evt = 1'b0;
    endcase
    case (auto_leave_trigger)
      3'b001: leave_evt = fifo_empty_evt;
      3'b010: leave_evt = rise[3] || timeout_in;
      3'b011: leave_evt = rise[2] || timeout_in;
      3'b100: leave_evt = rise[1] || timeout_in;
      3'b101: leave_evt = rise[0] || timeout_in;
      3'b111: leave_evt = timeout_in;
      default: leave_evt = 1'b0;
    endcase
    next_temp_active = temp_active;
    if (auto_entry_trigger == 3'b000 || auto_leave_trigger == 3'b000)
      next_temp_active = 1'b0;
    else if (!temp_active && entry_evt)
      next_temp_active = 1'b1;
    else if (temp_active && leave_evt)
      next_temp_active = 1'b0;
    // Reserved temporary code falls back to standby
    if (next_temp_active)
      next_mode = (temp_state_select == rph_pkg::MODE_RESERVED) ?
                  rph_pkg::MODE_STANDBY : temp_state_select;
    else
      next_mode = op_mode;
  end

  // Register file and interrupt logic
  always_comb
  begin
    next_packet_format_config = packet_format_config;
    next_payload_length = payload_length;
    next_own_node_address = own_node_address;
    next_broadcast_node_address = broadcast_node_address;
    next_auto_mode_sequencer = auto_mode_sequencer;
    next_fifo_level_threshold = fifo_level_threshold;
    next_irq_mask = irq_mask;
    next_op_mode = op_mode;
    next_irq_status = irq_status;
    next_prdata = prdata_out;
    next_pslverr = 1'b0;
    next_pready = psel_in && penable_in && !pready_out;
    irq_set = '0;
    irq_set[rph_pkg::IRQ_FRAME_MATCH] = rise[0];
    irq_set[rph_pkg::IRQ_BODY_COMPLETE] = rise[1];
    irq_set[rph_pkg::IRQ_CHECKSUM_GOOD] = rise[2];
    irq_set[rph_pkg::IRQ_QUEUE_ABOVE] = rise[3];
    irq_set[rph_pkg::IRQ_TEMP_ENTER] = next_temp_active && !temp_active;
    irq_set[rph_pkg::IRQ_CHECKSUM_BAD] = crc_fail_evt;
    if (wr_done && pstrb_in[0])
    begin
      if (fld_hit(paddr_in, rph_pkg::IDX_PACKET_FORMAT_CONFIG))
        next_packet_format_config = pwdata_in[7:0];
      if (fld_hit(paddr_in, rph_pkg::IDX_PAYLOAD_LENGTH))
        next_payload_length = pwdata_in[7:0];
      if (fld_hit(paddr_in, rph_pkg::IDX_OWN_NODE_ADDRESS))
        next_own_node_address = pwdata_in[7:0];
      if (fld_hit(paddr_in, rph_pkg::IDX_BROADCAST_NODE_ADDRESS))
        next_broadcast_node_address = pwdata_in[7:0];
      if (fld_hit(paddr_in, rph_pkg::IDX_AUTO_MODE_SEQUENCER))
        next_auto_mode_sequencer = pwdata_in[7:0];
      if (fld_hit(paddr_in, rph_pkg::IDX_FIFO_LEVEL_THRESHOLD))
        next_fifo_level_threshold = pwdata_in[7:0];
      if (fld_hit(paddr_in, rph_pkg::IDX_IRQ_STATUS))
        next_irq_status = irq_status & ~pwdata_in[5:0];
      if (fld_hit(paddr_in, rph_pkg::IDX_IRQ_MASK))
        next_irq_mask = pwdata_in[5:0];
      if (fld_hit(paddr_in, rph_pkg::IDX_OP_MODE))
        next_op_mode = pwdata_in[1:0];
    end
    // Set wins over a clear in the same cycle
    next_irq_status = next_irq_status | irq_set;
    if (psel_in && penable_in && !pready_out)
    begin
      next_prdata = 32'h0000_0000;
      case (paddr_in[11:2])
        {2'b00, rph_pkg::IDX_PACKET_FORMAT_CONFIG}: next_prdata[7:0] = packet_format_config;
        {2'b00, rph_pkg::IDX_PAYLOAD_LENGTH}: next_prdata[7:0] = payload_length;
        {2'b00, rph_pkg::IDX_OWN_NODE_ADDRESS}: next_prdata[7:0] = own_node_address;
        {2'b00, rph_pkg::IDX_BROADCAST_NODE_ADDRESS}: next_prdata[7:0] = broadcast_node_address;
        {2'b00, rph_pkg::IDX_AUTO_MODE_SEQUENCER}: next_prdata[7:0] = auto_mode_sequencer;
        {2'b00, rph_pkg::IDX_FIFO_LEVEL_THRESHOLD}: next_prdata[7:0] = fifo_level_threshold;
        {2'b00, rph_pkg::IDX_FLAG_STATUS}: next_prdata[6:0] = flag_status;
        {2'b00, rph_pkg::IDX_IRQ_STATUS}: next_prdata[5:0] = irq_status;
        {2'b00, rph_pkg::IDX_IRQ_MASK}: next_prdata[5:0] = irq_mask;
        {2'b00, rph_pkg::IDX_FIFO_DATA}:
          next_prdata[7:0] = queue_has_data_flag ? fifo_mem[fifo_rd] : 8'h00;
        {2'b00, rph_pkg::IDX_OP_MODE}: next_prdata[1:0] = op_mode;
        default: next_pslverr = 1'b1;
      endcase
      // Refused accesses read zero
      if (paddr_in[1:0] != 2'b00)
      begin
        next_pslverr = 1'b1;
        next_prdata = 32'h0000_0000;
      end
    end
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge clk_sys_in)
  begin
    // Storage has no reset so it can map onto RAM
    if (push && !queue_full && !flush)
      fifo_mem[fifo_wr] <= dec_byte;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      packet_format_config <= rph_pkg::RST_PACKET_FORMAT_CONFIG;
      payload_length <= rph_pkg::RST_PAYLOAD_LENGTH;
      own_node_address <= rph_pkg::RST_NODE_ADDRESS;
      broadcast_node_address <= rph_pkg::RST_NODE_ADDRESS;
      auto_mode_sequencer <= rph_pkg::RST_AUTO_MODE_SEQUENCER;
      fifo_level_threshold <= rph_pkg::RST_FIFO_LEVEL_THRESHOLD;
      irq_status <= '0;
      irq_mask <= rph_pkg::RST_IRQ_MASK;
      op_mode <= rph_pkg::MODE_STANDBY;
      prdata_out <= '0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      irq_out <= 1'b0;
      mode_out <= rph_pkg::MODE_STANDBY;
      mode_q <= rph_pkg::MODE_STANDBY;
      pkt_state <= rph_pkg::PS_HUNT;
      shift <= '0;
      bit_cnt <= '0;
      half <= 1'b0;
      first_chip <= 1'b0;
      lfsr <= rph_pkg::WHITEN_SEED;
      crc <= rph_pkg::CRC_SEED;
      crc_hi <= '0;
      byte_left <= '0;
      addr_pending <= 1'b0;
      frame_match <= 1'b0;
      body_complete <= 1'b0;
      checksum_good <= 1'b0;
      temp_active <= 1'b0;
      prev_flags <= '0;
      fifo_wr <= '0;
      fifo_rd <= '0;
      fifo_cnt <= '0;
    end
    else
    begin
      packet_format_config <= next_packet_format_config;
      payload_length <= next_payload_length;
      own_node_address <= next_own_node_address;
      broadcast_node_address <= next_broadcast_node_address;
      auto_mode_sequencer <= next_auto_mode_sequencer;
      fifo_level_threshold <= next_fifo_level_threshold;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      op_mode <= next_op_mode;
      prdata_out <= next_prdata;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
      irq_out <= next_irq;
      mode_out <= next_mode;
      mode_q <= next_mode;
      pkt_state <= next_pkt_state;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      half <= next_half;
      first_chip <= next_first_chip;
      lfsr <= next_lfsr;
      crc <= next_crc;
      crc_hi <= next_crc_hi;
      byte_left <= next_byte_left;
      addr_pending <= next_addr_pending;
      frame_match <= next_frame_match;
      body_complete <= next_body_complete;
      checksum_good <= next_checksum_good;
      temp_active <= next_temp_active;
      prev_flags <= {queue_above_limit_flag, checksum_good, body_complete, frame_match};
      fifo_wr <= next_fifo_wr;
      fifo_rd <= next_fifo_rd;
      fifo_cnt <= next_fifo_cnt;
    end
  end
endmodule

// file: shared/rph_pkg.sv
// Shared constants and types for the receive packet handler configuration block
package rph_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PACKET_FORMAT_CONFIG = 8'h37;
  localparam logic [7:0] IDX_PAYLOAD_LENGTH = 8'h38;
  localparam logic [7:0] IDX_OWN_NODE_ADDRESS = 8'h39;
  localparam logic [7:0] IDX_BROADCAST_NODE_ADDRESS = 8'h3A;
  localparam logic [7:0] IDX_AUTO_MODE_SEQUENCER = 8'h3B;
  localparam logic [7:0] IDX_FIFO_LEVEL_THRESHOLD = 8'h3C;
  localparam logic [7:0] IDX_FLAG_STATUS = 8'h50;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h51;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h52;
  localparam logic [7:0] IDX_FIFO_DATA = 8'h53;
  localparam logic [7:0] IDX_OP_MODE = 8'h54;

  // packet_format_config fields
  localparam int POS_LENGTH_FORMAT = 7;
  localparam int POS_DECODING_LO = 5;
  localparam int POS_CHECKSUM_ENABLE = 4;
  localparam int POS_CHECKSUM_FAIL_KEEP = 3;
  localparam int POS_ADDR_FILTER_LO = 1;
  // auto_mode_sequencer fields
  localparam int POS_ENTRY_LO = 5;
  localparam int POS_LEAVE_LO = 2;
  localparam int POS_TEMP_LO = 0;

  // Reset values
  localparam logic [7:0] RST_PACKET_FORMAT_CONFIG = 8'h10;
  localparam logic [7:0] RST_PAYLOAD_LENGTH = 8'h40;
  localparam logic [7:0] RST_NODE_ADDRESS = 8'h00;
  localparam logic [7:0] RST_AUTO_MODE_SEQUENCER = 8'h00;
  localparam logic [7:0] RST_FIFO_LEVEL_THRESHOLD = 8'h8F;
  localparam logic [5:0] RST_IRQ_MASK = 6'h00;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [8:0] WHITEN_SEED = 9'h1FF;

  // Flag status bit positions
  localparam int FLG_FRAME_MATCH = 0;
  localparam int FLG_BODY_COMPLETE = 1;
  localparam int FLG_CHECKSUM_GOOD = 2;
  localparam int FLG_QUEUE_ABOVE = 3;
  localparam int FLG_QUEUE_HAS_DATA = 4;
  localparam int FLG_IN_TEMP_STATE = 5;
  localparam int FLG_QUEUE_FULL = 6;
  // Interrupt status bit positions
  localparam int IRQ_FRAME_MATCH = 0;
  localparam int IRQ_BODY_COMPLETE = 1;
  localparam int IRQ_CHECKSUM_GOOD = 2;
  localparam int IRQ_QUEUE_ABOVE = 3;
  localparam int IRQ_TEMP_ENTER = 4;
  localparam int IRQ_CHECKSUM_BAD = 5;

  typedef enum logic [1:0] {MODE_SLEEP, MODE_STANDBY, MODE_RECEIVE, MODE_RESERVED} rph_mode_e;
  typedef enum logic [1:0] {DEC_NONE, DEC_MANCHESTER, DEC_WHITEN, DEC_RESERVED} rph_dec_e;
  typedef enum logic [1:0] {FILT_OFF, FILT_NODE, FILT_NODE_BCAST, FILT_RESERVED} rph_filt_e;
  typedef enum {PS_HUNT, PS_LEN, PS_BODY, PS_CRC_HI, PS_CRC_LO, PS_HOLD} rph_pkt_e;
endpackage

// file: testbench/rph_checker_asserts.sv
// Port checker for the receive packet handler
`timescale 1ns/1ps
module rph_checker (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [1:0] mode_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence s_acc;
    psel_in && penable_in && !pready_out;
  endsequence
  a_ready_next: assert property (s_acc |=> pready_out)
    else $error("ready missing after access");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_err_zero: assert property (pslverr_out |-> prdata_out == 32'h0)
    else $error("error read not zero");
  a_width_zero: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  a_misalign_err: assert property (s_acc ##0 paddr_in[1:0] != 2'h0 |=> pslverr_out)
    else $error("misaligned access accepted");
  a_cfg_ok: assert property (s_acc ##0 (paddr_in[1:0] == 2'h0 &&
    paddr_in[11:2] inside {[10'h037:10'h03C]}) |=> !pslverr_out) else $error("config refused");
  a_mode_legal: assert property (mode_out != 2'h3)
    else $error("reserved mode shown");
endmodule
bind rph_packet_handler rph_checker u_chk (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
  .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .mode_out(mode_out));

// file: testbench/rph_tx_model.sv
// Remote transmitter model sending raw chips, MSB first
`timescale 1ns/1ps
module rph_tx_model (
  input wire logic clk_in,
  output logic chip_out,
  output logic valid_out,
  output logic sync_out
);
  initial {chip_out, valid_out, sync_out} = 3'h0;
  task automatic sync_pulse;
    @(posedge clk_in) sync_out <= 1'b1;
    @(posedge clk_in) sync_out <= 1'b0;
  endtask
  // Idle line shows the inverse chip so a stale value never looks valid
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clk_in) {chip_out, valid_out} <= {b[i], 1'b1};
      @(posedge clk_in) {chip_out, valid_out} <= {~b[i], 1'b0};
    end
  endtask
endmodule

// file: testbench/rph_packet_handler_tb.sv
// Self-checking bench for the receive packet handler
`timescale 1ns/1ps
module rph_packet_handler_tb;
  logic clk_sys_in, rstn_in, psel, penable, pwrite, chip, valid, sync, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] mode;
  logic tmo;
  int failures = 0;
  int compares = 0;
  typedef struct {logic w; logic [7:0] i; logic [7:0] d; logic [7:0] x;} rph_row_s;
  rph_row_s rows [11] = '{'{0, 8'h37, 0, 8'h10}, '{0, 8'h38, 0, 8'h40}, '{0, 8'h39, 0, 8'h00},
    '{0, 8'h3A, 0, 8'h00}, '{0, 8'h3B, 0, 8'h00}, '{0, 8'h3C, 0, 8'h8F}, '{1, 8'h39, 8'hA5, 8'hA5},
    '{1, 8'h3A, 8'h5A, 8'h5A}, '{1, 8'h3B, 8'h0A, 8'h0A}, '{1, 8'h3C, 8'h02, 8'h02},
    '{1, 8'h37, 8'hAA, 8'hAA}};
  rph_packet_handler u_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .rx_chip_in(chip), .rx_chip_valid_in(valid), .sync_found_in(sync), .timeout_in(tmo),
    .mode_out(mode), .irq_out(irq));
  rph_tx_model u_tx (.clk_in(clk_sys_in), .chip_out(chip), .valid_out(valid), .sync_out(sync));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // Request holds until the rising edge that samples pready; read data is taken there
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d, input logic [1:0] lo);
    @(posedge clk_sys_in) {psel, pwrite, paddr, pwdata} <= {1'b1, w, 2'b00, i, lo, 24'h0, d};
    @(posedge clk_sys_in) penable <= 1'b1;
    do @(posedge clk_sys_in); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    give_verdict();
  end
  initial
  begin
    {rstn_in, psel, penable, pwrite, paddr, pwdata, tmo} = '0;
    repeat (3) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    chk(32'(mode), 32'h1);
    foreach (rows[k])
    begin
      if (rows[k].w) apb(1'b1, rows[k].i, rows[k].d, 2'h0);
      apb(1'b0, rows[k].i, 8'h00, 2'h0);
      chk(rd, 32'(rows[k].x));
    end
    apb(1'b1, rph_pkg::IDX_PACKET_FORMAT_CONFIG, 8'h80, 2'h0);
    apb(1'b1, rph_pkg::IDX_IRQ_MASK, 8'h02, 2'h0);
    apb(1'b1, rph_pkg::IDX_OP_MODE, 8'h02, 2'h0);
    u_tx.sync_pulse();
    foreach (rows[k]) if (k < 3) u_tx.send(8'h02 + 8'(k) * 8'h55);
    repeat (2) @(posedge clk_sys_in);
    apb(1'b0, rph_pkg::IDX_FLAG_STATUS, 8'h00, 2'h0);
    chk(rd, 32'h1B);
    chk(32'(irq), 32'h1);
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b0, rph_pkg::IDX_FIFO_DATA, 8'h00, 2'h0);
      chk(rd, 32'h02 + 32'(k) * 32'h55);
      apb(1'b0, rph_pkg::IDX_FLAG_STATUS, 8'h00, 2'h0);
      chk(rd, k == 0 ? 32'h13 : k == 1 ? 32'h13 : 32'h00);
    end
    apb(1'b1, rph_pkg::IDX_IRQ_STATUS, 8'hFF, 2'h0);
    @(posedge clk_sys_in);
    chk(32'(irq), 32'h0);
    // Frame match rise enters standby; a timeout pulse returns to receive
    apb(1'b1, rph_pkg::IDX_AUTO_MODE_SEQUENCER, 8'hBD, 2'h0);
    u_tx.sync_pulse();
    repeat (3) @(posedge clk_sys_in);
    chk(32'(mode), 32'h1);
    @(posedge clk_sys_in) tmo <= 1'b1;
    @(posedge clk_sys_in) tmo <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    chk(32'(mode), 32'h2);
    apb(1'b0, 8'h37, 8'h00, 2'h1);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 8'h00, 2'h0);
    chk(32'(err), 32'h1);
    give_verdict();
  end
endmodule
